// >>> sim/cmd_merge_chk.sv
/* port checks on the merge block; bound by port name onto drive_command_source_merge */
`timescale 1ns/1ns
`default_nettype none
module cmd_merge_chk #(parameter int CW_W = 16) (
  input wire logic i_clk, i_sys_rst, i_term_qstop_n, i_term_dc_brake_n, i_sel_load,
  input wire logic [1:0] i_term_setup, i_bus_setup, o_setup_code,
  input wire logic [CW_W-1:0] i_ctrl_word,
  input wire logic o_qstop_active, o_dc_brake_active, o_start, o_reverse,
  input wire logic i_term_start, i_ser_start, i_term_reverse, i_ser_reverse,
  input wire logic [2:0] o_setup_num
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  q_run_a:
    assert property (i_term_qstop_n && i_ctrl_word[4] |=> !o_qstop_active) else $error("q");
  q_stop_a:
    assert property (!i_term_qstop_n && !i_ctrl_word[4] |=> o_qstop_active) else $error("q");
  dc_run_a:
    assert property (i_term_dc_brake_n && i_ctrl_word[2] |=> !o_dc_brake_active) else $error("d");
  dc_brake_a:
    assert property (!i_term_dc_brake_n && !i_ctrl_word[2] |=> o_dc_brake_active) else $error("d");
  setup_same_a:
    assert property (i_term_setup == i_bus_setup |=> o_setup_code == $past(i_term_setup)) else $error("s");
  setup_num_a:
    assert property (o_setup_num == {1'b0, o_setup_code} + 3'h1) else $error("n");
  reset_vals_a:
    assert property ($fell(i_sys_rst) |-> o_qstop_active && !o_start && o_setup_num == 3'h1) else $error("r");
  hold_still_a:
    assert property (!$past(i_sys_rst) && !i_sel_load && !$past(i_sel_load) && !$past(i_sel_load, 2)
      && $stable(i_term_dc_brake_n) && $stable(i_ctrl_word) |=> $stable(o_dc_brake_active)) else $error("h");
  start_both_a:
    assert property (i_term_start && i_ser_start |=> o_start) else $error("start");
  rev_none_a:
    assert property (!i_term_reverse && !i_ser_reverse |=> !o_reverse) else $error("reverse");
  cover property (o_start);
  cover property (o_reverse);
  cover property ($rose(o_qstop_active));
  cover property (o_setup_num == 3'h4);
endmodule // cmd_merge_chk
bind drive_command_source_merge cmd_merge_chk #(.CW_W(CW_W)) i_chk (.*);
`default_nettype wire

// >>> sim/drive_command_source_merge_tb_top.sv
/* bench: walks every source mode over all level pairs; needs model and checker */
`timescale 1ns/1ns
`default_nettype none
module drive_command_source_merge_tb_top;
  import cmd_merge_pkg::*;
  logic clk = 0, rst = 1, t = 0, s = 0, ld = 0, r, qa, da, st, rv;
  src_sel_t sel = 2'h0;
  logic [15:0] cw;
  logic [1:0] cd, e;
  logic [2:0] num;
  int n_errors = 0, n_tests = 0;
  far_side_model i_far (.i_s(s), .o_cw(cw));
  drive_command_source_merge i_dut (.i_clk(clk), .i_sys_rst(rst), .i_term_qstop_n(t),
    .i_term_dc_brake_n(t), .i_term_start(t), .i_term_reverse(t), .i_ser_start(s),
    .i_ser_reverse(s), .i_term_setup({t, s}),
    .i_ctrl_word(cw), .i_bus_setup({s, t}), .i_sel_qstop(sel), .i_sel_dc_brake(sel),
    .i_sel_start(sel), .i_sel_reverse(sel), .i_sel_setup(sel), .i_sel_load(ld),
    .o_qstop_active(qa), .o_dc_brake_active(da), .o_start(st), .o_reverse(rv),
    .o_setup_code(cd), .o_setup_num(num));
  task automatic chk(input string nm, input logic [2:0] x, input logic [2:0] g);
    n_tests++;
    if (g !== x)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial
  begin
    #5000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(negedge clk);
    chk("reset", 3'h6, {qa, da, st});
    rst = 0;
    // mode 3 runs first without a load so the reset selection is exercised
    for (int m = 3; m >= 0; m--)
    begin
      if (m != 3)
      begin
        sel = m[1:0];
        ld = 1;
        @(negedge clk);
        ld = 0;
      end
      for (int c = 0; c < 4; c++)
      begin
        t = c[1];
        s = c[0];
        @(negedge clk);
        r = m == 0 ? t : m == 1 ? s : m == 2 ? t | s : t & s;
        e = m == 0 ? {t, s} : m == 1 ? {s, t} : {2{m == 2 ? t & s : t | s}};
        chk("qstop", !r, qa);
        chk("dc", !r, da);
        chk("setup", {1'b0, e} + 3'h1, num);
        r = m == 0 ? t : m == 1 ? s : m == 2 ? t & s : t | s;
        chk("start_rev", {r, r}, {st, rv});
      end
    end
    repeat (4) @(negedge clk);
    tally_and_finish();
  end
endmodule // drive_command_source_merge_tb_top
`default_nettype wire

// >>> sim/far_side_model.sv
/* far side: serial control word from one permit level; bench sets it off the edge */
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
  input  wire logic        i_s,
  output logic      [15:0] o_cw
);
  assign o_cw = {16{i_s}};
endmodule // far_side_model
`default_nettype wire

// >>> src/cmd_merge_defines.svh
/*
  Constants for the command-source merge block: selection codes,
  control word bit positions and reset values.
  Assumes nothing of its surroundings beyond inclusion by bare name.
*/
`ifndef CMD_MERGE_DEFINES_SVH
`define CMD_MERGE_DEFINES_SVH

`define SRC_TERMINAL    2'h0
`define SRC_SERIAL      2'h1
`define SRC_AND         2'h2
`define SRC_OR          2'h3
`define SRC_RESET       2'h3

`define CW_WIDTH        16
`define CW_BIT_DC_BRAKE 2
`define CW_BIT_QSTOP    4

`define SETUP_RESET     2'h0
`define RUN_RESET       1'b0
`define CMD_RESET       1'b0
`define SETUP_NUM_BASE  3'h1

`endif

// >>> src/cmd_merge_pkg.sv
/*
  Types shared by the command-source merge block.
  Uses none of the defines; assumes nothing of its surroundings.
*/
package cmd_merge_pkg;
  typedef logic [1:0] src_sel_t;

  typedef struct packed {
    src_sel_t   sel_qstop;
    src_sel_t   sel_dc;
    src_sel_t   sel_start;
    src_sel_t   sel_rev;
    src_sel_t   sel_setup;
    logic       qstop_run;
    logic       dc_run;
    logic       start;
    logic       ccw;
    logic [1:0] setup;
  } merge_state_t;
endpackage

// >>> src/drive_command_source_merge.sv
/*
  Merges terminal commands with serial sources for quick-stop, DC brake,
  start, reversing and setup selection (control word bits for quick-stop
  and DC brake only), each under its own 2-bit source selection.
  Outputs are registered once per clock.
  Selection codes: 0 terminal only, 1 serial only, 2 AND, 3 OR; all
  five reset to OR.
  Quick-stop and DC brake travel as active-low run permits, so their
  AND and OR codes swap the gate: AND runs on either permit and OR
  needs both. Start and reversing are active high and use the plain
  gate. Setup selection combines the two-bit codes bit by bit.
  Assumes terminal levels, control word and selection codes are
  synchronous to i_clk; the block keeps its own copy of the selection
  codes, reloaded on every edge while i_sel_load is high.
  Assumes the control word is already unpacked from its telegram.
*/
// Behaviour
// - each function has a 2-bit source: terminal, serial, AND, OR.
// - quick-stop terminal and control word bit 4 are active low.
// - quick-stop runs per mode; mode 2 either high, mode 3 both high.
// - DC-brake terminal and control word bit 2 are active low.
// - DC brake runs per mode; mode 2 either high, mode 3 both high.
// - start: mode 2 needs both high, mode 3 either high.
// - direction 1 is anti-clockwise; mode 2 AND, mode 3 OR.
// - setup code 00..11 picks setup 1..4; mode 2 bitwise AND, 3 OR.
// - serial-only mode ignores the terminal input.
`timescale 1ns/1ns
`default_nettype none
`include "cmd_merge_defines.svh"

module drive_command_source_merge
  import cmd_merge_pkg::*;
#(
  parameter int CW_W = `CW_WIDTH
)(
  input  wire logic            i_clk,
  input  wire logic            i_sys_rst,
  input  wire logic            i_term_qstop_n,
  input  wire logic            i_term_dc_brake_n,
  input  wire logic            i_term_start,
  input  wire logic            i_term_reverse,
  input  wire logic            i_ser_start,
  input  wire logic            i_ser_reverse,
  input  wire logic [1:0]      i_term_setup,
  input  wire logic [CW_W-1:0] i_ctrl_word,
  input  wire logic [1:0]      i_bus_setup,
  input  wire logic [1:0]      i_sel_qstop,
  input  wire logic [1:0]      i_sel_dc_brake,
  input  wire logic [1:0]      i_sel_start,
  input  wire logic [1:0]      i_sel_reverse,
  input  wire logic [1:0]      i_sel_setup,
  input  wire logic            i_sel_load,
  output logic                 o_qstop_active,
  output logic                 o_dc_brake_active,
  output logic                 o_start,
  output logic                 o_reverse,
  output logic [1:0]           o_setup_code,
  output logic [2:0]           o_setup_num
);

  // ****************************************
  // source selection store
  // ****************************************
  // selection codes sit in the state struct with the merged results
  merge_state_t state_r;
  merge_state_t state_nxt;

  // ****************************************
  // command inputs gathered per function
  // ****************************************
  // terminal and serial sources for each function, by polarity
  logic       qstop_term_n;
  logic       qstop_ser_n;
  logic       dc_term_n;
  logic       dc_ser_n;
  logic       start_term;
  logic       start_ser;
  logic       rev_term;
  logic       rev_ser;
  logic [1:0] setup_term;
  logic [1:0] setup_bus;
  logic [1:0] setup_and;
  logic [1:0] setup_or;

  assign qstop_term_n = i_term_qstop_n;
  assign qstop_ser_n  = i_ctrl_word[`CW_BIT_QSTOP];
  assign dc_term_n    = i_term_dc_brake_n;
  assign dc_ser_n     = i_ctrl_word[`CW_BIT_DC_BRAKE];
  assign start_term   = i_term_start;
  assign start_ser    = i_ser_start;
  assign rev_term     = i_term_reverse;
  assign rev_ser      = i_ser_reverse;
  assign setup_term   = i_term_setup;
  assign setup_bus    = i_bus_setup;

  // msb and lsb of the setup code combine independently
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_setup_bit
      assign setup_and[gi] = setup_term[gi] & setup_bus[gi];
      assign setup_or[gi]  = setup_term[gi] | setup_bus[gi];
    end
  endgenerate

  // ****************************************
  // merge functions
  // ****************************************
  // active-high merge: AND mode needs both, OR mode either
  function automatic logic merge_hi(input src_sel_t sel, input logic t, input logic s);
    logic r;
    r = 1'b0;
    unique case (sel)
      `SRC_TERMINAL: r = t;
      `SRC_SERIAL:   r = s;
      `SRC_AND:      r = t & s;
      `SRC_OR:       r = t | s;
    endcase
    return r;
  endfunction

  // active-low run permits: code 2 runs on either, code 3 needs both
  function automatic logic merge_run(input src_sel_t sel, input logic t, input logic s);
    logic r;
    r = 1'b0;
    unique case (sel)
      `SRC_TERMINAL: r = t;
      `SRC_SERIAL:   r = s;
      `SRC_AND:      r = t | s;
      `SRC_OR:       r = t & s;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] merge_setup(input src_sel_t sel, input logic [1:0] t,
                                             input logic [1:0] b, input logic [1:0] a,
                                             input logic [1:0] o);
    logic [1:0] r;
    r = 2'h0;
    unique case (sel)
      `SRC_TERMINAL: r = t;
      `SRC_SERIAL:   r = b;
      `SRC_AND:      r = a;
      `SRC_OR:       r = o;
    endcase
    return r;
  endfunction

  // ****************************************
  // state update
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    // a code loaded here governs the merge from the following edge on
    if (i_sel_load)
    begin
      state_nxt.sel_qstop = i_sel_qstop;
      state_nxt.sel_dc    = i_sel_dc_brake;
      state_nxt.sel_start = i_sel_start;
      state_nxt.sel_rev   = i_sel_reverse;
      state_nxt.sel_setup = i_sel_setup;
    end
    state_nxt.qstop_run = merge_run(state_r.sel_qstop, qstop_term_n,
                                    qstop_ser_n);
    state_nxt.dc_run    = merge_run(state_r.sel_dc, dc_term_n,
                                    dc_ser_n);
    state_nxt.start     = merge_hi(state_r.sel_start, start_term,
                                   start_ser);
    state_nxt.ccw       = merge_hi(state_r.sel_rev, rev_term,
                                   rev_ser);
    state_nxt.setup     = merge_setup(state_r.sel_setup, setup_term, setup_bus,
                                      setup_and, setup_or);
  end

  // ****************************************
  // state register
  // ****************************************
  // reset holds both stop requests active until the first merged edge;
  // selection codes reset to OR so both sources count from the start
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_r.sel_qstop <= `SRC_RESET;
      state_r.sel_dc    <= `SRC_RESET;
      state_r.sel_start <= `SRC_RESET;
      state_r.sel_rev   <= `SRC_RESET;
      state_r.sel_setup <= `SRC_RESET;
      state_r.qstop_run <= `RUN_RESET;
      state_r.dc_run    <= `RUN_RESET;
      state_r.start     <= `CMD_RESET;
      state_r.ccw       <= `CMD_RESET;
      state_r.setup     <= `SETUP_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // stop flags are the inverse of the registered run permits
  assign o_qstop_active    = ~state_r.qstop_run;
  assign o_dc_brake_active = ~state_r.dc_run;
  assign o_start           = state_r.start;
  assign o_reverse         = state_r.ccw;
  assign o_setup_code      = state_r.setup;
  // setup number is one above the code, 1 to 4
  assign o_setup_num       = {1'b0, state_r.setup} + `SETUP_NUM_BASE;

endmodule // drive_command_source_merge
`default_nettype wire
